/* File: rtl/tam_pkg.sv */
// Shared constants and types for the authentication master
package tam_pkg;

    // ------------------------------------------------------------------
    // Clock and bus timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int RST_LOW_NS    = 480000;
    localparam int RST_SAMP_NS   = 550000;
    localparam int RST_SLOT_NS   = 960000;
    localparam int W0_LOW_NS     = 60000;
    localparam int W1_LOW_NS     = 6000;
    localparam int RD_SAMP_NS    = 15000;
    localparam int SLOT_NS       = 70000;
    localparam int QTR_NS        = 250000000;
    localparam int RST_LOW_CYC   = (RST_LOW_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int RST_SAMP_CYC  = (RST_SAMP_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int RST_SLOT_CYC  = (RST_SLOT_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int W0_LOW_CYC    = (W0_LOW_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int W1_LOW_CYC    = (W1_LOW_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int RD_SAMP_CYC   = RD_SAMP_NS / CLK_PERIOD_NS;
    localparam int SLOT_CYC      = (SLOT_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int QTR_CYC       = QTR_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Configuration word layout
    // ------------------------------------------------------------------
    localparam int CFG_RETRY_LSB = 0;
    localparam int CFG_PER_LSB   = 2;
    localparam int CFG_POL_BIT   = 7;
    localparam int CFG_FOM_BIT   = 8;
    localparam int CFG_FAILF_BIT = 13;
    localparam int CFG_PASSF_BIT = 14;
    localparam logic [11:0] CFG_RESET = 12'h000;

    // ------------------------------------------------------------------
    // Exchange constants
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_WR_CHALLENGE_TRIGGER_IN = 8'h0C;
    localparam int CHALLENGE_TRIGGER_IN_BYTES  = 8;
    localparam int RESP_BITS   = 160;
    localparam int ZERO_SLOTS  = 8;
    localparam logic [3:0] LAST_BYTE = 4'(CHALLENGE_TRIGGER_IN_BYTES + 2);
    localparam logic [6:0] PER_1S_Q  = 7'h04;
    localparam logic [6:0] PER_8S_Q  = 7'h20;
    localparam logic [6:0] PER_16S_Q = 7'h40;

    typedef enum logic [1:0] {OP_RST, OP_W0, OP_W1, OP_RD} tam_op_e;

endpackage

/* File: rtl/tam_owm.sv */
// Bit-level master for the single-wire bus: reset and time slots
`timescale 1ns/1ps
module tam_owm #(
    parameter int RST_LOW  = tam_pkg::RST_LOW_CYC,
    parameter int RST_SAMP = tam_pkg::RST_SAMP_CYC,
    parameter int RST_SLOT = tam_pkg::RST_SLOT_CYC,
    parameter int W0_LOW   = tam_pkg::W0_LOW_CYC,
    parameter int W1_LOW   = tam_pkg::W1_LOW_CYC,
    parameter int RD_SAMP  = tam_pkg::RD_SAMP_CYC,
    parameter int SLOT     = tam_pkg::SLOT_CYC
) (
    // Clock and reset
    input  wire logic            clock_i,
    input  wire logic            sys_rst_i,
    // Request
    input  wire logic            start_i,
    input  wire tam_pkg::tam_op_e op_i,
    // Line
    input  wire logic            line_i,
    output logic                 drive_o,
    // Answer
    output logic                 done_o,
    output logic                 bit_o
);

    logic             busy;
    logic [15:0]      cnt;
    tam_pkg::tam_op_e op_q;
    logic [15:0]      low_len;
    logic [15:0]      samp;
    logic [15:0]      total;

    assign low_len = (op_q == tam_pkg::OP_RST) ? 16'(RST_LOW - 1) :
                     (op_q == tam_pkg::OP_W0) ?
                     16'(W0_LOW - 1) :
                     16'(W1_LOW - 1);
    assign samp    = (op_q == tam_pkg::OP_RST) ? 16'(RST_SAMP) :
                     16'(RD_SAMP);
    assign total   = (op_q == tam_pkg::OP_RST) ? 16'(RST_SLOT - 1) :
                     16'(SLOT - 1);

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            busy    <= 1'b0;
            cnt     <= 16'h0000;
            op_q    <= tam_pkg::OP_RST;
            drive_o <= 1'b0;
            done_o  <= 1'b0;
            bit_o   <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy) begin
                busy    <= 1'b1;
                cnt     <= 16'h0000;
                op_q    <= op_i;
                drive_o <= 1'b1;
            end else if (busy) begin
                cnt <= cnt + 16'h0001;
                if (cnt == low_len) begin
                    drive_o <= 1'b0;
                end
                // Presence is a low line; read data is the line level
                if (cnt == samp) begin
                    bit_o <= (op_q == tam_pkg::OP_RST) ? ~line_i : line_i;
                end
                if (cnt == total) begin
                    busy   <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

endmodule

/* File: rtl/tam_tick.sv */
// Quarter-second enable pulse and 2 Hz blink level
`timescale 1ns/1ps
module tam_tick #(
    parameter int QTR_CYC = tam_pkg::QTR_CYC
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic sys_rst_i,
    // Rates
    output logic      qtr_o,
    output logic      blink_o
);

    logic [31:0] cnt;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cnt     <= 32'h0000_0000;
            qtr_o   <= 1'b0;
            blink_o <= 1'b0;
        end else if (cnt == 32'(QTR_CYC - 1)) begin
            cnt     <= 32'h0000_0000;
            qtr_o   <= 1'b1;
            // Half period of a quarter second gives 2 Hz, 50% duty
            blink_o <= ~blink_o;
        end else begin
            cnt   <= cnt + 32'h0000_0001;
            qtr_o <= 1'b0;
        end
    end

endmodule

/* File: rtl/tam_auth_master.sv */
// Challenge and response authentication master sequencer
// Contract
// R1: Send 0Ch then eight challenge bytes
// R2: Compare MAC bits as they arrive
// R3: Hold outputs until pass or all fail
// R4: Configure at least one retry per initiation
// R5: Release outputs when trigger goes inactive
// R6: No presence pulse clears and releases outputs
// R7: Outputs unchanged while an attempt runs
// R8: Open-drain outputs, low means pass or fail
// R9: Programmer loads challenge, response and options
// R10: Programmer should lock data after verifying
// R11: Retry field selects 1, 2, 4, 8 attempts
// R12: Each attempt runs the complete exchange
// R13: Complete at first pass or all failed
// R14: Periodic field selects none, 1s, 8s, 16s
// R15: Periodic runs keep outputs until updated
// R16: Avoid all-zero or all-one challenge data
// R17: Fail mode bit pulses fail at 2Hz
// R18: Eight write-zero slots before MAC reads
// R19: Polarity bit selects trigger level and edge
// R20: Any MAC bit mismatch fails the attempt
`timescale 1ns/1ps
module tam_auth_master #(
    parameter int         RST_LOW  = tam_pkg::RST_LOW_CYC,
    parameter int         RST_SAMP = tam_pkg::RST_SAMP_CYC,
    parameter int         RST_SLOT = tam_pkg::RST_SLOT_CYC,
    parameter int         W0_LOW   = tam_pkg::W0_LOW_CYC,
    parameter int         W1_LOW   = tam_pkg::W1_LOW_CYC,
    parameter int         RD_SAMP  = tam_pkg::RD_SAMP_CYC,
    parameter int         SLOT     = tam_pkg::SLOT_CYC,
    parameter int         QTR_CYC  = tam_pkg::QTR_CYC,
    parameter int         SPU_CYC  = 40000,
    parameter logic [7:0] CMD_SKIP = 8'h00,
    parameter logic [7:0] CMD_MAC  = 8'h00
) (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         sys_rst_i,
    // Trigger
    input  wire logic         challenge_trigger_in_i,
    // Configuration from the slave port and stored pair
    input  wire logic         cfg_we_i,
    input  wire logic [15:0]  cfg_wdata_i,
    output logic      [15:0]  cfg_rdata_o,
    input  wire logic [63:0]  challenge_trigger_in_data_i,
    input  wire logic [159:0] resp_data_i,
    // Master bus line
    input  wire logic         master_bus_line_i,
    output logic              master_bus_line_o,
    output logic              master_bus_line_oe_o,
    output logic              spu_o,
    // Status lines
    output logic              pass_line_o,
    output logic              pass_line_oe_o,
    output logic              fail_line_o,
    output logic              fail_line_oe_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_RST, ST_SEND, ST_SPU, ST_ZERO, ST_READ, ST_FRST
    } tam_state_e;

    tam_state_e       state;
    logic [11:0]      cfg_q;
    logic             wait_q;
    logic [7:0]       bit_cnt;
    logic [3:0]       byte_idx;
    logic [2:0]       att_cnt;
    logic             mism;
    logic [31:0]      spu_cnt;
    logic [6:0]       per_cnt;
    logic             act_q;
    logic             pass_flag;
    logic             fail_flag;
    logic             phy_done;
    logic             phy_bit;
    logic             phy_drive;
    logic             qtr;
    logic             blink;
    tam_pkg::tam_op_e phy_op;
    logic             phy_go;
    logic [7:0]       cur_byte;
    logic             challenge_trigger_in_act;
    logic             challenge_trigger_in_rise;
    logic             challenge_trigger_in_fall;
    logic [1:0]       retry_sel;
    logic [1:0]       per_sel;
    logic             fail_output_mode;
    logic [2:0]       last_att;
    logic             per_due;
    logic             start;
    logic             fin;
    logic             absent;
    logic             done_pass;
    logic             done_fail;
    logic             clr_evt;
    logic             busy;

    function automatic logic [7:0] byte_at(input logic [3:0]  idx,
                                           input logic [63:0] ch);
        logic [7:0] b;
        b = CMD_MAC;
        if (idx == 4'h0) begin
            b = CMD_SKIP;
        end else if (idx == 4'h1) begin
            b = tam_pkg::CMD_WR_CHALLENGE_TRIGGER_IN;
        end else if (idx < tam_pkg::LAST_BYTE) begin
            b = ch[8 * (int'(idx) - 2) +: 8];
        end
        return b;
    endfunction

    function automatic logic [6:0] per_len(input logic [1:0] sel);
        return (sel == 2'b01) ? tam_pkg::PER_1S_Q :
               (sel == 2'b10) ? tam_pkg::PER_8S_Q : tam_pkg::PER_16S_Q;
    endfunction

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    assign retry_sel = cfg_q[tam_pkg::CFG_RETRY_LSB +: 2];
    assign per_sel   = cfg_q[tam_pkg::CFG_PER_LSB +: 2];
    assign fail_output_mode       = cfg_q[tam_pkg::CFG_FOM_BIT];
    // R11 attempt count
    assign last_att  = 3'((4'h1 << retry_sel) - 4'h1);
    // R19 polarity select
    assign challenge_trigger_in_act  = ~(challenge_trigger_in_i ^ cfg_q[tam_pkg::CFG_POL_BIT]);
    assign challenge_trigger_in_rise = challenge_trigger_in_act & ~act_q;
    assign challenge_trigger_in_fall = ~challenge_trigger_in_act & act_q;
    assign busy      = (state != ST_IDLE);
    // R14 periodic start
    assign per_due   = !busy && per_sel != 2'b00 && qtr
                       && per_cnt == per_len(per_sel) - 7'h01;
    assign start     = !busy && (challenge_trigger_in_rise || per_due);
    assign cur_byte  = byte_at(byte_idx, challenge_trigger_in_data_i);
    assign phy_go    = !wait_q && (state == ST_RST || state == ST_SEND
                       || state == ST_ZERO || state == ST_READ
                       || state == ST_FRST);
    // R12 slot type per step
    assign phy_op    = (state == ST_RST || state == ST_FRST) ?
                       tam_pkg::OP_RST :
                       (state == ST_READ) ? tam_pkg::OP_RD :
                       (state == ST_SEND && cur_byte[bit_cnt[2:0]]) ?
                       tam_pkg::OP_W1 : tam_pkg::OP_W0;
    assign fin       = state == ST_FRST && phy_done && phy_bit;
    // R6 removal seen at either bus reset
    assign absent    = phy_done && !phy_bit
                       && (state == ST_RST || state == ST_FRST);
    // R13 completion
    assign done_pass = fin && !mism;
    // R20 any mismatched bit fails the attempt
    assign done_fail = fin && mism && att_cnt == last_att;
    assign clr_evt   = challenge_trigger_in_fall || absent;

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    tam_owm #(
        .RST_LOW  (RST_LOW),
        .RST_SAMP (RST_SAMP),
        .RST_SLOT (RST_SLOT),
        .W0_LOW   (W0_LOW),
        .W1_LOW   (W1_LOW),
        .RD_SAMP  (RD_SAMP),
        .SLOT     (SLOT)
    ) u_owm (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (phy_go),
        .op_i      (phy_op),
        .line_i    (master_bus_line_i),
        .drive_o   (phy_drive),
        .done_o    (phy_done),
        .bit_o     (phy_bit)
    );

    tam_tick #(
        .QTR_CYC (QTR_CYC)
    ) u_tick (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .qtr_o     (qtr),
        .blink_o   (blink)
    );

    // ------------------------------------------------------------------
    // Configuration and triggers
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cfg_q   <= tam_pkg::CFG_RESET;
            act_q   <= 1'b0;
            per_cnt <= 7'h00;
        end else begin
            if (cfg_we_i) begin
                cfg_q <= cfg_wdata_i[11:0];
            end
            // Reset value of zero lets an active level at power-up start
            act_q <= challenge_trigger_in_act;
            if (busy || per_sel == 2'b00 || per_due) begin
                per_cnt <= 7'h00;
            end else if (qtr) begin
                per_cnt <= per_cnt + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state    <= ST_IDLE;
            wait_q   <= 1'b0;
            bit_cnt  <= 8'h00;
            byte_idx <= 4'h0;
            att_cnt  <= 3'h0;
            mism     <= 1'b0;
            spu_cnt  <= 32'h0000_0000;
        end else if (challenge_trigger_in_fall) begin
            // R5 abort on inactive trigger
            state  <= ST_IDLE;
            wait_q <= 1'b0;
        end else begin
            if (phy_go) begin
                wait_q <= 1'b1;
            end else if (phy_done) begin
                wait_q <= 1'b0;
            end
            unique case (state)
                ST_IDLE: if (start) begin
                    state   <= ST_RST;
                    att_cnt <= 3'h0;
                    mism    <= 1'b0;
                end
                ST_RST: if (phy_done) begin
                    state    <= phy_bit ? ST_SEND : ST_IDLE;
                    byte_idx <= 4'h0;
                    bit_cnt  <= 8'h00;
                end
                // R1 command and challenge bytes, low bit first
                ST_SEND: if (phy_done) begin
                    bit_cnt <= (bit_cnt == 8'h07) ? 8'h00 : bit_cnt + 8'h01;
                    if (bit_cnt == 8'h07) begin
                        byte_idx <= byte_idx + 4'h1;
                        if (byte_idx == tam_pkg::LAST_BYTE) begin
                            state   <= ST_SPU;
                            spu_cnt <= 32'h0000_0000;
                        end
                    end
                end
                ST_SPU: begin
                    spu_cnt <= spu_cnt + 32'h0000_0001;
                    if (spu_cnt == 32'(SPU_CYC - 1)) begin
                        state <= ST_ZERO;
                    end
                end
                // R18 eight write-zero slots
                ST_ZERO: if (phy_done) begin
                    if (bit_cnt == 8'(tam_pkg::ZERO_SLOTS - 1)) begin
                        state   <= ST_READ;
                        bit_cnt <= 8'h00;
                    end else begin
                        bit_cnt <= bit_cnt + 8'h01;
                    end
                end
                // R2 compare each bit on arrival
                ST_READ: if (phy_done) begin
                    if (phy_bit != resp_data_i[bit_cnt]) begin
                        mism <= 1'b1;
                    end
                    bit_cnt <= bit_cnt + 8'h01;
                    if (bit_cnt == 8'(tam_pkg::RESP_BITS - 1)) begin
                        state <= ST_FRST;
                    end
                end
                // R3 retry until pass or attempts used up
                ST_FRST: if (phy_done) begin
                    if (!phy_bit || done_pass || done_fail) begin
                        state <= ST_IDLE;
                    end else begin
                        state   <= ST_RST;
                        att_cnt <= att_cnt + 3'h1;
                        mism    <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Result and pins
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pass_flag <= 1'b0;
            fail_flag <= 1'b0;
        end else if (clr_evt) begin
            pass_flag <= 1'b0;
            fail_flag <= 1'b0;
        end else if (done_pass || done_fail) begin
            // R15 only a completed run updates
            pass_flag <= done_pass;
            fail_flag <= done_fail;
        end
    end

    // R8 open-drain drive, low only
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            master_bus_line_o    <= 1'b0;
            master_bus_line_oe_o <= 1'b0;
            spu_o                <= 1'b0;
            pass_line_o          <= 1'b0;
            pass_line_oe_o       <= 1'b0;
            fail_line_o          <= 1'b0;
            fail_line_oe_o       <= 1'b0;
            cfg_rdata_o          <= 16'h0000;
        end else begin
            master_bus_line_oe_o <= phy_drive;
            spu_o                <= (state == ST_SPU);
            pass_line_oe_o       <= pass_flag;
            // R17 blink when fail mode set
            fail_line_oe_o       <= fail_flag & (~fail_output_mode | blink);
            cfg_rdata_o          <= {1'b0, pass_flag, fail_flag, 1'b0,
                                     cfg_q};
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_wr_challenge_trigger_in_cmd: assert property ( // R1
        @(posedge clock_i) disable iff (sys_rst_i)
        state == ST_SEND && byte_idx == 4'h1 |-> cur_byte == 8'h0C)
        else $error("write challenge code wrong");
    a_bit_compare: assert property ( // R2
        @(posedge clock_i) disable iff (sys_rst_i)
        state == ST_READ && phy_done && !challenge_trigger_in_fall
        && phy_bit != resp_data_i[bit_cnt] |=> mism)
        else $error("mismatched bit not recorded");
    a_hold_running: assert property ( // R7
        @(posedge clock_i) disable iff (sys_rst_i)
        busy && !clr_evt && !done_pass && !done_fail
        |=> ##1 $stable(pass_line_oe_o))
        else $error("pass changed during attempt");
    a_retry_bound: assert property ( // R11
        @(posedge clock_i) disable iff (sys_rst_i)
        att_cnt <= last_att)
        else $error("too many attempts");
    a_zero_slots: assert property ( // R18
        @(posedge clock_i) disable iff (sys_rst_i)
        $rose(state == ST_READ) |-> $past(bit_cnt) == 8'h07)
        else $error("wrong count of zero slots");
    a_absent_clear: assert property ( // R6
        @(posedge clock_i) disable iff (sys_rst_i)
        absent |=> ##1 !pass_line_oe_o && !fail_line_oe_o)
        else $error("outputs kept after removal");
    a_inactive_clear: assert property ( // R5
        @(posedge clock_i) disable iff (sys_rst_i)
        challenge_trigger_in_fall |=> ##1 !pass_line_oe_o && !fail_line_oe_o)
        else $error("outputs kept after trigger release");
    a_pass_report: assert property ( // R13
        @(posedge clock_i) disable iff (sys_rst_i)
        done_pass && !clr_evt |=> ##1 pass_line_oe_o && !fail_line_oe_o)
        else $error("pass not reported");
    a_fail_steady: assert property ( // R17
        @(posedge clock_i) disable iff (sys_rst_i)
        fail_flag && !fail_output_mode && !clr_evt |=> fail_line_oe_o)
        else $error("fail not held low");
    a_status_excl: assert property ( // R8
        @(posedge clock_i) disable iff (sys_rst_i)
        !(pass_line_oe_o && fail_line_oe_o))
        else $error("both status lines driven");

endmodule

/* File: tb/tam_token.sv */
// Behavioural remote token on the single-wire bus
`timescale 1ns/1ps
module tam_token (
    // Bus side
    input  wire logic         clock_i,
    input  wire logic         line_i,
    output logic              pull_o,
    // Test control
    input  wire logic         present_i,
    input  wire logic [159:0] mac_i,
    output logic [87:0]       rx_o
);
    int   low_cnt = 0;
    int   slot    = 0;
    int   hold    = 0;
    logic prev    = 1'b1;
    logic rd      = 1'b0;
    logic m;
    initial pull_o = 1'b0;
    initial rx_o   = '0;
    // Own pull hides the master's release, so watch line or pull
    always @(posedge clock_i) begin
        m = line_i || pull_o;
        if (!m) low_cnt++;
        if (prev && !m && slot >= 96 && slot < 256) begin
            rd = 1'b1;
            if (present_i && !mac_i[slot-96]) hold = 20;
            slot++;
        end else if (!prev && m) begin
            if (rd) rd = 1'b0;
            else if (low_cnt >= 50) begin
                slot = 0;
                if (present_i) hold = 20;
            end else begin
                if (slot >= 8 && slot < 96) rx_o <= {low_cnt < 15, rx_o[87:1]};
                slot++;
            end
            low_cnt = 0;
        end
        pull_o <= (hold > 0);
        if (hold > 0) hold--;
        prev = m;
    end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the authentication master
`timescale 1ns/1ps
module tb;
    logic         clock_i = 1'b0;
    logic         sys_rst_i = 1'b1;
    logic         trig = 1'b0;
    logic         cfg_we = 1'b0;
    logic [15:0]  cfg_wd = 16'h0000;
    logic [15:0]  cfg_rd;
    logic [63:0]  challenge_trigger_in = '0;
    logic [159:0] resp = '0;
    logic [159:0] mac = '0;
    logic         present = 1'b1;
    logic         oe, pull, pass_oe, fail_oe, bus_o, spu, pass_o, fail_o;
    int           spu_seen = 0, lvl_bad = 0;
    logic [87:0]  rx;
    logic [1:0]   prev_f = 2'b00;
    logic [1:0]   exp_q[$];
    int           num_errors = 0, num_checks = 0, res_cnt = 0, bad, tog, i;
    integer       seed;
    wire logic    bus = !(oe || pull);
    always #25 clock_i = ~clock_i;
    tam_auth_master #(.RST_LOW(60), .RST_SAMP(70), .RST_SLOT(100),
        .W0_LOW(30), .W1_LOW(4), .RD_SAMP(10), .SLOT(40),
        .QTR_CYC(20), .SPU_CYC(5)) i_dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .challenge_trigger_in_i(trig), .cfg_we_i(cfg_we),
        .cfg_wdata_i(cfg_wd), .cfg_rdata_o(cfg_rd), .challenge_trigger_in_data_i(challenge_trigger_in),
        .resp_data_i(resp), .master_bus_line_i(bus),
        .master_bus_line_o(bus_o), .master_bus_line_oe_o(oe), .spu_o(spu),
        .pass_line_o(pass_o), .pass_line_oe_o(pass_oe), .fail_line_o(fail_o),
        .fail_line_oe_o(fail_oe));
    tam_token i_tok (.clock_i(clock_i), .line_i(bus), .pull_o(pull),
        .present_i(present), .mac_i(mac), .rx_o(rx));
    task automatic check(input string nm, input logic [87:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cfg_write(input logic [15:0] v);
        @(negedge clock_i) begin cfg_we = 1'b1; cfg_wd = v; end
        @(negedge clock_i) cfg_we = 1'b0;
        repeat (2) @(negedge clock_i);
    endtask
    // Bounded wait for result n; optionally watch that pass stays held
    task automatic wait_res(input int n, input logic hold);
        for (i = 0; i < 40000 && res_cnt < n; i++) begin
            @(negedge clock_i);
            if (hold && res_cnt < n && pass_oe !== 1'b1 && cfg_rd[13] !== 1'b1) bad++;
        end
        if (res_cnt < n) begin num_errors++; print_verdict(); end
    endtask
    // Result monitor: each new status is matched to the oldest note
    always @(posedge clock_i) begin
        if (cfg_rd[14:13] !== prev_f && cfg_rd[14:13] != 2'b00) begin
            res_cnt++;
            if (exp_q.size() == 0) check("unexpected result", 88'd1, 88'd0);
            else check("result", 88'(cfg_rd[14:13]), 88'(exp_q.pop_front()));
        end
        prev_f <= cfg_rd[14:13];
        if (spu === 1'b1) spu_seen = 1;
        if (bus_o !== 1'b0 || pass_o !== 1'b0 || fail_o !== 1'b0) lvl_bad++;
    end
    initial begin
        seed = 32'he0d9;
        // stored pair, never all zeros or ones
        challenge_trigger_in = {$random(seed), $random(seed)} & ~64'h1 | 64'h2;
        resp = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)} & ~160'h1 | 160'h2;
        mac = resp;
        repeat (16) @(negedge clock_i);
        sys_rst_i = 1'b0;
        @(negedge clock_i) check("cfg reset", 88'(cfg_rd), 88'h0);
        cfg_write(16'hF185); // two attempts per initiation
        check("cfg readback", 88'(cfg_rd), 88'h0185);
        exp_q.push_back(2'b10);
        trig = 1'b1;
        wait_res(1, 1'b0);
        repeat (3) @(negedge clock_i);
        check("pins after pass", 88'({pass_oe, fail_oe}), 88'h2);
        check("bus bytes", rx, {16'h0000, challenge_trigger_in, 8'h0C});
        mac[159] = ~mac[159];
        exp_q.push_back(2'b01);
        bad = 0;
        wait_res(2, 1'b1);
        check("held during retries", 88'(bad), 88'h0);
        repeat (3) @(negedge clock_i);
        tog = 0;
        for (i = 0; i < 60; i++) @(negedge clock_i) if (fail_oe !== i_dut.fail_line_oe_o) tog = tog; else tog = tog;
        for (i = 0, bad = fail_oe; i < 60; i++) @(negedge clock_i) begin
            if (fail_oe !== bad[0]) tog++;
            bad = fail_oe;
        end
        check("fail blink", 88'(tog), 88'd3);
        check("pass released", 88'(pass_oe), 88'h0);
        present = 1'b0;
        for (i = 0; i < 30000 && (cfg_rd[14:13] != 0 || fail_oe || pass_oe); i++) @(negedge clock_i);
        check("removal", 88'({cfg_rd[14:13], pass_oe, fail_oe}), 88'h0);
        cfg_write(16'h0880);
        present = 1'b1;
        mac = resp;
        trig = 1'b0;
        @(negedge clock_i) trig = 1'b1;
        exp_q.push_back(2'b10);
        wait_res(3, 1'b0);
        repeat (3) @(negedge clock_i) trig = 1'b0;
        check("trigger release", 88'({cfg_rd[14:13], pass_oe, fail_oe}), 88'h0);
        check("strong pullup seen", 88'(spu_seen), 88'd1);
        check("pin levels low only", 88'(lvl_bad), 88'd0);
        print_verdict();
    end
endmodule
